/* File: include/stl_pkg.sv */
package stl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Frame layout, first bit on the wire lands in the top bit
    localparam int FRAME_BITS = 10;
    localparam int DATA_BITS  = 6;
    localparam int ADDR_BITS  = 4;
    localparam int DIGITS     = 10;
    localparam int ADDR_LSB   = 0;
    localparam int DATA_LSB   = 4;
    localparam int CODE_LSB   = 0;
    localparam int CODE_BITS  = 4;
    localparam int IND1_BIT   = 4;
    localparam int IND2_BIT   = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Display drive
    localparam int ROWS        = 3;
    localparam int PHASES      = 6;
    localparam int LINES       = 3 * DIGITS;
    localparam int CLK_MHZ     = 100;
    localparam int PHASE_US    = 2000;
    localparam int PHASE_CYCLES = PHASE_US * CLK_MHZ;

    typedef logic [1:0] stl_level_t;
    localparam stl_level_t LVL_SS  = 2'h0;
    localparam stl_level_t LVL_P1  = 2'h1;
    localparam stl_level_t LVL_P2  = 2'h2;
    localparam stl_level_t LVL_DD  = 2'h3;
    localparam logic [6:0] SEG_RST = 7'h00;

    // Character code to segments {a,b,c,d,e,f,g}
    function automatic logic [6:0] stl_decode(input logic [3:0] code);
        logic [6:0] s;
        s = 7'h00;
        case (code)
            4'h0: s = 7'h7e;  4'h1: s = 7'h30;  4'h2: s = 7'h6d;  4'h3: s = 7'h79;
            4'h4: s = 7'h33;  4'h5: s = 7'h5b;  4'h6: s = 7'h5f;  4'h7: s = 7'h70;
            4'h8: s = 7'h7f;  4'h9: s = 7'h7b;  4'ha: s = 7'h01;  4'hb: s = 7'h4f;
            4'hc: s = 7'h37;  4'hd: s = 7'h0e;  4'he: s = 7'h67;  default: s = 7'h00;
        endcase
        return s;
    endfunction

endpackage

/* File: include/stl_frame_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface stl_frame_if;
    import stl_pkg::*;
    logic                  shift_edge;
    logic                  shift_bit;
    logic                  write_edge;
    logic                  complete;
    logic                  commit;
    logic [FRAME_BITS-1:0] frame;

    modport loader (input shift_edge, shift_bit, write_edge, output complete, commit, frame);
    modport ctrl   (output shift_edge, shift_bit, write_edge, input complete, commit, frame);
endinterface
`default_nettype wire

/* File: rtl/stl_shift_loader.sv */
`timescale 1ns/1ps
`default_nettype none
module stl_shift_loader
    import stl_pkg::*;
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rst,
    // Frame carrier
    stl_frame_if.loader f
);

    logic [FRAME_BITS-1:0] sr_q,  sr_d;
    logic [3:0]            cnt_q, cnt_d;
    logic                  full_q, full_d;
    logic                  commit_q, commit_d;
    logic [FRAME_BITS-1:0] frame_q, frame_d;
    logic                  seen_q, seen_d;
    logic                  full_now;

    assign full_now = (cnt_q == 4'(FRAME_BITS));

    always_comb begin
        sr_d     = sr_q;
        cnt_d    = cnt_q;
        commit_d = 1'b0;
        frame_d  = frame_q;
        seen_d   = full_q;
        if (f.write_edge) begin
            // The pin lags the count by one clock; a write in that gap sees it high and only resets
            commit_d = full_now && seen_q;
            if (commit_d) begin
                frame_d = sr_q;
            end
            sr_d  = '0;
            cnt_d = 4'h0;
        end else if (f.shift_edge) begin
            if (full_now) begin
                sr_d  = '0;
                cnt_d = 4'h0;
            end else begin
                sr_d  = {sr_q[FRAME_BITS-2:0], f.shift_bit};
                cnt_d = cnt_q + 4'h1;
            end
        end
        full_d = (cnt_d == 4'(FRAME_BITS));
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sr_q     <= '0;
            cnt_q    <= 4'h0;
            full_q   <= 1'b0;
            seen_q   <= 1'b0;
            commit_q <= 1'b0;
            frame_q  <= '0;
        end else begin
            sr_q     <= sr_d;
            cnt_q    <= cnt_d;
            full_q   <= full_d;
            seen_q   <= seen_d;
            commit_q <= commit_d;
            frame_q  <= frame_d;
        end
    end

    assign f.complete = full_q;
    assign f.commit   = commit_q;
    assign f.frame    = frame_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_eleventh_clears: assert property (f.shift_edge && !f.write_edge && full_now |=> cnt_q == 4'h0 && sr_q == '0)
        else $error("extra data clock edge did not clear loader");
    a_shift_advance: assert property (f.shift_edge && !f.write_edge && !full_now
        |=> sr_q[0] == $past(f.shift_bit) && sr_q[FRAME_BITS-1:1] == $past(sr_q[FRAME_BITS-2:0]))
        else $error("shift register did not advance");
    a_write_resets: assert property (f.write_edge |=> cnt_q == 4'h0 && !full_q)
        else $error("write strobe did not reset loader");
endmodule // stl_shift_loader
`default_nettype wire

/* File: rtl/stl_mux_drive.sv */
`timescale 1ns/1ps
`default_nettype none
module stl_mux_drive
    import stl_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // Timing and picture
    input  wire logic [2:0]           phase,
    input  wire logic                 shutdown,
    input  wire logic [3*LINES-1:0]   seg_on,
    // Levels
    output var  logic [2*ROWS-1:0]    com_level,
    output var  logic [2*LINES-1:0]   seg_level
);

    logic [2*ROWS-1:0]  com_d;
    logic [2*LINES-1:0] seg_d;
    logic [1:0]         row;
    logic               primed;

    // Primed half inverts polarity so no line carries DC
    always_comb begin
        primed = (phase >= 3'h3);
        row    = primed ? 2'(phase - 3'h3) : phase[1:0];
        com_d  = '0;
        seg_d  = '0;
        for (int r = 0; r < ROWS; r++) begin
            if (shutdown) begin
                com_d[2*r +: 2] = LVL_DD;
            end else if (row == 2'(r)) begin
                com_d[2*r +: 2] = primed ? LVL_SS : LVL_DD;
            end else begin
                com_d[2*r +: 2] = primed ? LVL_P2 : LVL_P1;
            end
        end
        for (int j = 0; j < LINES; j++) begin
            if (shutdown) begin
                seg_d[2*j +: 2] = LVL_DD;
            end else if (seg_on[3*j + 32'(row)]) begin
                seg_d[2*j +: 2] = primed ? LVL_DD : LVL_SS;
            end else begin
                seg_d[2*j +: 2] = primed ? LVL_P1 : LVL_P2;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            com_level <= {ROWS{LVL_DD}};
            seg_level <= {LINES{LVL_DD}};
        end else begin
            com_level <= com_d;
            seg_level <= seg_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_shutdown_levels: assert property (shutdown |=> com_level == {ROWS{LVL_DD}} && seg_level == {LINES{LVL_DD}})
        else $error("shutdown did not park lines at supply");
    a_off_third: assert property (!shutdown && !seg_on[0] && phase == 3'h0
        |=> seg_level[1:0] == LVL_P2 && com_level[1:0] == LVL_DD)
        else $error("off intersection not held at one third");
endmodule // stl_mux_drive
`default_nettype wire

/* File: rtl/stl_lcd_loader.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Serial data bit is high for one, low for zero, stored in shift register.
// - Each rising data clock edge moves the shift register by one place.
// - An extra edge after a full frame clears register and loading logic.
// - Frame-complete handshake goes low only with exactly ten bits loaded.
// - Write edge with ten bits loaded and handshake low updates addressed digit, then resets loader.
// - Write edge with handshake high only resets the loader.
// - Frame holds six data bits and four address bits for ten digits.
// - Data splits into four-bit character code and two indicator bits.
// - Bias input near supply forces shutdown: lines to supply, data kept.
// - Display timing runs from a free internal divider, not the data clock.
// - Each segment line serves top, middle, bottom segments on commons one to three.
// - Off intersections see one third peak, on-to-off ratio is 1.92.
// - Indicator bit one lights its indicator, zero blanks it.
module stl_lcd_loader
    import stl_pkg::*;
#(
    parameter int PHASE_DIV = PHASE_CYCLES
)(
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // Host serial port
    input  wire logic                 serial_data,
    input  wire logic                 serial_clk,
    input  wire logic                 write_strobe,
    output var  logic                 frame_complete_ack_n,
    // Bias sense, high when open or near supply
    input  wire logic                 display_bias_input,
    // Display lines
    output var  logic [1:0]           common_row_one,
    output var  logic [1:0]           common_row_two,
    output var  logic [1:0]           common_row_three,
    output var  logic [2*LINES-1:0]   segment_line
);

    if (PHASE_DIV < 2) begin : g_div_check
        $error("PHASE_DIV must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host edge detection

    logic sclk_q, sclk_d;
    logic wr_q,   wr_d;
    logic shut_q, shut_d;
    logic ack_n_q, ack_n_d;

    stl_frame_if f ();

    always_comb begin
        sclk_d = serial_clk;
        wr_d   = write_strobe;
        shut_d = display_bias_input;
        ack_n_d = !f.complete;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sclk_q  <= 1'b0;
            wr_q    <= 1'b0;
            shut_q  <= 1'b0;
            ack_n_q <= 1'b1;
        end else begin
            sclk_q  <= sclk_d;
            wr_q    <= wr_d;
            shut_q  <= shut_d;
            ack_n_q <= ack_n_d;
        end
    end

    // Shutdown halts the loader too, so a host talking into a dead panel changes nothing
    assign f.shift_edge = serial_clk && !sclk_q && !shut_q;
    assign f.shift_bit  = serial_data;
    assign f.write_edge = write_strobe && !wr_q && !shut_q;
    assign frame_complete_ack_n = ack_n_q;

    stl_shift_loader u_loader (
        .clock (clock),
        .rst   (rst),
        .f     (f.loader)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Digit store

    logic [DATA_BITS-1:0] digit_q [DIGITS];
    logic [DATA_BITS-1:0] digit_d [DIGITS];
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] data;

    assign addr = f.frame[ADDR_LSB +: ADDR_BITS];
    assign data = f.frame[DATA_LSB +: DATA_BITS];

    // Addresses above the last digit are dropped quietly
    always_comb begin
        for (int i = 0; i < DIGITS; i++) begin
            digit_d[i] = digit_q[i];
        end
        if (f.commit && addr < ADDR_BITS'(DIGITS)) begin
            digit_d[addr] = data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < DIGITS; i++) begin
                digit_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DIGITS; i++) begin
                digit_q[i] <= digit_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal timebase, free of the host clock

    logic [31:0] div_q,   div_d;
    logic [2:0]  phase_q, phase_d;

    always_comb begin
        div_d   = div_q;
        phase_d = phase_q;
        if (!shut_q) begin
            if (div_q == 32'(PHASE_DIV - 1)) begin
                div_d   = 32'h0;
                phase_d = (phase_q == 3'(PHASES - 1)) ? 3'h0 : phase_q + 3'h1;
            end else begin
                div_d = div_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            div_q   <= 32'h0;
            phase_q <= 3'h0;
        end else begin
            div_q   <= div_d;
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Segment map: three lines per digit, rows top, middle, bottom

    logic [3*LINES-1:0] seg_on;
    logic [6:0]         segs;

    always_comb begin
        seg_on = '0;
        segs   = SEG_RST;
        for (int i = 0; i < DIGITS; i++) begin
            segs = stl_decode(digit_q[i][CODE_LSB +: CODE_BITS]);
            // Line a/g/d
            seg_on[9*i + 0] = segs[6];
            seg_on[9*i + 1] = segs[0];
            seg_on[9*i + 2] = segs[3];
            // Line f/e/indicator two
            seg_on[9*i + 3] = segs[1];
            seg_on[9*i + 4] = segs[2];
            seg_on[9*i + 5] = digit_q[i][IND2_BIT];
            // Line b/c/indicator one
            seg_on[9*i + 6] = segs[5];
            seg_on[9*i + 7] = segs[4];
            seg_on[9*i + 8] = digit_q[i][IND1_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line drivers

    logic [2*ROWS-1:0] com_level;

    stl_mux_drive u_drive (
        .clock     (clock),
        .rst       (rst),
        .phase     (phase_q),
        .shutdown  (shut_q),
        .seg_on    (seg_on),
        .com_level (com_level),
        .seg_level (segment_line)
    );

    assign common_row_one   = com_level[1:0];
    assign common_row_two   = com_level[3:2];
    assign common_row_three = com_level[5:4];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // Second model of count and shift register, kept apart from the loader
    // so the handshake and committed frame are judged independently
    logic [3:0]            chk_cnt_q, chk_cnt_d;
    logic [FRAME_BITS-1:0] chk_sr_q,  chk_sr_d;

    always_comb begin
        chk_cnt_d = chk_cnt_q;
        chk_sr_d  = chk_sr_q;
        if (f.write_edge || (f.shift_edge && chk_cnt_q == 4'(FRAME_BITS))) begin
            chk_cnt_d = 4'h0;
            chk_sr_d  = '0;
        end else if (f.shift_edge) begin
            chk_cnt_d = chk_cnt_q + 4'h1;
            chk_sr_d  = {chk_sr_q[FRAME_BITS-2:0], f.shift_bit};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            chk_cnt_q <= 4'h0;
            chk_sr_q  <= '0;
        end else begin
            chk_cnt_q <= chk_cnt_d;
            chk_sr_q  <= chk_sr_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_digit_update: assert property (f.commit && addr < ADDR_BITS'(DIGITS) |=> digit_q[$past(addr)] == $past(data))
        else $error("addressed digit not updated");
    a_write_only_reset: assert property (f.write_edge && ack_n_q |=> !f.commit ##1 $stable(digit_q[0]))
        else $error("write with handshake high changed a digit");
    a_commit_needs_ack: assert property (f.commit |-> $past(f.write_edge) && $past(!ack_n_q))
        else $error("commit without a full frame");
    a_ack_after_ten: assert property (!ack_n_q |-> $past(f.complete))
        else $error("handshake low without a full frame");
    a_ack_rises_extra: assert property (!ack_n_q && f.shift_edge && !f.write_edge |-> ##2 ack_n_q)
        else $error("handshake stayed low after extra edge");
    a_phase_steps: assert property (!shut_q && div_q == 32'(PHASE_DIV - 1) |=> phase_q != $past(phase_q))
        else $error("display phase did not advance");
    a_phase_hold: assert property (shut_q |=> $stable(phase_q) && $stable(div_q))
        else $error("timebase ran in shutdown");
    a_common_one_phase: assert property (!shut_q && phase_q == 3'h0 ##1 !shut_q |-> common_row_one == LVL_DD)
        else $error("first common not active in first phase");
    a_ind_on: assert property (!shut_q && phase_q == 3'h2 && digit_q[0][IND1_BIT] |=> segment_line[5:4] == LVL_SS)
        else $error("indicator one not lit");
    a_ind_two: assert property (!shut_q && phase_q == 3'h2 && digit_q[0][IND2_BIT] |=> segment_line[3:2] == LVL_SS)
        else $error("indicator two not lit");
    a_ind_primed: assert property (!shut_q && phase_q == 3'h5 && digit_q[0][IND1_BIT]
        |=> segment_line[5:4] == LVL_DD)
        else $error("indicator one not lit in primed half");
    a_code_eight: assert property (!shut_q && phase_q == 3'h0 && digit_q[0][CODE_LSB +: CODE_BITS] == 4'h8
        |=> segment_line[1:0] == LVL_SS)
        else $error("top segment of code eight not lit");

    // Handshake and frame
    a_shut_no_commit: assert property (shut_q |=> !f.commit)
        else $error("commit in shutdown");
    a_shut_freezes: assert property (shut_q ##1 shut_q |=> $stable(ack_n_q))
        else $error("handshake moved in shutdown");
    a_write_clears_ack: assert property (f.write_edge |-> ##2 ack_n_q)
        else $error("handshake still low after write");
    a_ack_holds: assert property (f.complete && !f.write_edge && !f.shift_edge |-> ##2 !ack_n_q)
        else $error("handshake rose with no edge");
    a_ack_matches_count: assert property (ack_n_q == !$past(chk_cnt_q == 4'(FRAME_BITS)))
        else $error("handshake disagrees with bit count");
    a_frame_matches: assert property (f.commit |-> f.frame == $past(chk_sr_q))
        else $error("committed frame differs from shifted bits");
    a_digit_other_kept: assert property (f.commit && addr != 4'h0 |=> $stable(digit_q[0]))
        else $error("unaddressed digit changed");
    a_high_addr_ignored: assert property (f.commit && addr >= ADDR_BITS'(DIGITS)
        |=> $stable(digit_q[DIGITS-1]))
        else $error("address above last digit changed a digit");

    // Timebase and drive levels
    a_div_counts: assert property (!shut_q && div_q != 32'(PHASE_DIV - 1)
        |=> div_q == $past(div_q) + 32'h1)
        else $error("divider did not count");
    a_phase_range: assert property (phase_q < 3'(PHASES))
        else $error("phase out of range");
    a_div_range: assert property (div_q < 32'(PHASE_DIV))
        else $error("divider out of range");
    a_phase_wrap: assert property (!shut_q && div_q == 32'(PHASE_DIV - 1) && phase_q == 3'(PHASES - 1)
        |=> phase_q == 3'h0)
        else $error("phase did not wrap");
    a_common_primed: assert property (!shut_q && phase_q == 3'h3 |=> common_row_one == LVL_SS)
        else $error("first common not low in primed half");
    a_common_two_phase: assert property (!shut_q && phase_q == 3'h1 |=> common_row_two == LVL_DD)
        else $error("second common not active");
    a_common_three_phase: assert property (!shut_q && phase_q == 3'h2 |=> common_row_three == LVL_DD)
        else $error("third common not active");
    a_mid_level: assert property (!shut_q && phase_q == 3'h1 |=> common_row_one == LVL_P1 && common_row_three == LVL_P1)
        else $error("idle commons not at one third");
    a_primed_idle: assert property (!shut_q && phase_q == 3'h4 |=> common_row_one == LVL_P2 && common_row_three == LVL_P2)
        else $error("idle commons not at two thirds");
    a_shut_dark_top: assert property (shut_q |=> common_row_two == LVL_DD && segment_line == {LINES{LVL_DD}})
        else $error("lines not at supply in shutdown");

    c_frame_written:   cover property (f.commit && addr < ADDR_BITS'(DIGITS));
    c_extra_edge:      cover property (!ack_n_q && f.shift_edge && !f.write_edge);
    c_write_early:     cover property (f.write_edge && ack_n_q);
    c_shutdown_entry:  cover property ($rose(shut_q));
    c_digit_nine:      cover property (f.commit && addr == 4'h9);

endmodule // stl_lcd_loader
`default_nettype wire

/* File: bench/stl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module stl_host_model (
    // Clock
    input  wire logic clock,
    // Serial port toward the device
    output var  logic serial_data,
    output var  logic serial_clk,
    output var  logic write_strobe
);

    // Lines start low so release of reset sees no false rising edge
    initial begin
        serial_data  = 1'b0;
        serial_clk   = 1'b0;
        write_strobe = 1'b0;
    end

    // No chip select pin exists here, so no idle level can drift to test mode

    ////////////////////////////////////////////////////////////////////////////
    // Each level is held for two clocks so the device sees a low sample between edges
    task automatic send_bit(input logic b);
        @(negedge clock);
        serial_data = b;
        serial_clk  = 1'b1;
        repeat (2) @(negedge clock);
        serial_clk  = 1'b0;
        // Released data line shows the inverse, never the stale bit
        serial_data = ~b;
        @(negedge clock);
    endtask

    // Indicator two first, then indicator one, code and address, top bit first
    task automatic send_frame(input logic [9:0] f);
        for (int i = 9; i >= 0; i--) begin
            send_bit(f[i]);
        end
    endtask

    task automatic write_frame();
        @(negedge clock);
        write_strobe = 1'b1;
        repeat (2) @(negedge clock);
        write_strobe = 1'b0;
        repeat (2) @(negedge clock);
    endtask

endmodule // stl_host_model
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import stl_pkg::*;

    // Short phase keeps a full drive cycle to a few dozen clocks
    localparam int DIV = 4;

    logic               clock;
    logic               rst;
    logic               serial_data;
    logic               serial_clk;
    logic               write_strobe;
    logic               ack_n;
    logic               bias;
    logic [1:0]         com1;
    logic [1:0]         com2;
    logic [1:0]         com3;
    logic [2*LINES-1:0] seg;
    int                 err_count;
    int                 cmp_count;

    stl_host_model host (
        .clock       (clock),
        .serial_data (serial_data),
        .serial_clk  (serial_clk),
        .write_strobe(write_strobe)
    );

    stl_lcd_loader #(.PHASE_DIV(DIV)) dut (
        .clock               (clock),
        .rst                 (rst),
        .serial_data         (serial_data),
        .serial_clk          (serial_clk),
        .write_strobe        (write_strobe),
        .frame_complete_ack_n(ack_n),
        .display_bias_input  (bias),
        .common_row_one      (com1),
        .common_row_two      (com2),
        .common_row_three    (com3),
        .segment_line        (seg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check_dark();
        check("commons at supply", {5'h0, &com1, &com2, &com3}, 8'h07);
        check("segments at supply", {7'h0, &seg}, 8'h01);
    endtask

    // Walks all six phases and judges the three lines of one digit in each
    task automatic check_digit(input int idx, input logic [6:0] s, input logic i1, input logic i2);
        logic [2:0] on [3];
        logic [1:0] com [3];
        logic [5:0] seen_ph;
        logic       pr;
        int         act;
        logic [7:0] want;
        on[0] = {s[3], s[0], s[6]};
        on[1] = {i2, s[2], s[1]};
        on[2] = {i1, s[4], s[5]};
        seen_ph = 6'h00;
        repeat (6*DIV+2) begin
            @(negedge clock);
            com = '{com1, com2, com3};
            pr = (com1 == 2'h0) || (com2 == 2'h0) || (com3 == 2'h0);
            act = -1;
            for (int r = 0; r < 3; r++) begin
                if (com[r] == (pr ? 2'h0 : 2'h3)) act = r;
            end
            if (act >= 0) begin
                seen_ph[act + (pr ? 3 : 0)] = 1'b1;
                for (int r = 0; r < 3; r++) begin
                    check("common level", {6'h0, com[r]}, r == act ? (pr ? 8'h0 : 8'h3) : (pr ? 8'h2 : 8'h1));
                end
                for (int l = 0; l < 3; l++) begin
                    want = on[l][act] ? (pr ? 8'h3 : 8'h0) : (pr ? 8'h1 : 8'h2);
                    check("segment level", {6'h0, seg[2*(3*idx+l) +: 2]}, want);
                end
            end
        end
        check("phases seen", {2'h0, seen_ph}, 8'h3f);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        repeat (4) @(negedge clock);
        check("handshake in reset", {7'h0, ack_n}, 8'h1);
        check_dark();
        rst = 1'b0;
    endtask

    task automatic t_write();
        host.send_frame({2'b11, 4'h8, 4'h0});
        check("handshake full", {7'h0, ack_n}, 8'h0);
        host.write_frame();
        check("handshake after write", {7'h0, ack_n}, 8'h1);
        check_digit(0, 7'h7f, 1'b1, 1'b1);
        host.send_frame({2'b01, 4'h3, 4'h9});
        host.write_frame();
        check_digit(9, 7'h79, 1'b1, 1'b0);
        check_digit(0, 7'h7f, 1'b1, 1'b1);
    endtask

    // Eleventh edge wipes the entry, so the following write only resets
    task automatic t_count();
        logic [9:0] f;
        f = {2'b00, 4'h1, 4'h0};
        for (int i = 9; i >= 1; i--) begin
            host.send_bit(f[i]);
        end
        check("handshake nine bits", {7'h0, ack_n}, 8'h1);
        host.send_bit(f[0]);
        check("handshake ten bits", {7'h0, ack_n}, 8'h0);
        host.send_bit(1'b0);
        check("handshake eleven bits", {7'h0, ack_n}, 8'h1);
        host.write_frame();
        check_digit(0, 7'h7f, 1'b1, 1'b1);
        host.send_frame(f);
        check("handshake after clear", {7'h0, ack_n}, 8'h0);
        host.write_frame();
        check_digit(0, 7'h30, 1'b0, 1'b0);
    endtask

    task automatic t_reject();
        host.send_frame({2'b11, 4'h8, 4'ha});
        check("handshake address ten", {7'h0, ack_n}, 8'h0);
        host.write_frame();
        check("handshake reset", {7'h0, ack_n}, 8'h1);
        check_digit(0, 7'h30, 1'b0, 1'b0);
    endtask

    task automatic t_shutdown();
        @(negedge clock);
        bias = 1'b1;
        repeat (3) @(negedge clock);
        check_dark();
        host.send_frame({2'b11, 4'h8, 4'h0});
        check("handshake in shutdown", {7'h0, ack_n}, 8'h1);
        host.write_frame();
        check_dark();
        bias = 1'b0;
        repeat (2) @(negedge clock);
        check_digit(0, 7'h30, 1'b0, 1'b0);
    endtask

    // Reset in mid-frame drops the partial entry and returns every digit to code zero
    task automatic t_midreset();
        for (int i = 0; i < 5; i++) begin
            host.send_bit(1'b1);
        end
        rst = 1'b1;
        repeat (2) @(negedge clock);
        check_dark();
        rst = 1'b0;
        check("handshake after reset", {7'h0, ack_n}, 8'h1);
        check_digit(0, 7'h7e, 1'b0, 1'b0);
        host.send_frame({2'b00, 4'h1, 4'h0});
        check("handshake fresh frame", {7'h0, ack_n}, 8'h0);
        host.write_frame();
        check_digit(0, 7'h30, 1'b0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Run control
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        err_count = 0;
        cmp_count = 0;
        rst       = 1'b1;
        bias      = 1'b0;
        t_reset();
        t_write();
        t_count();
        t_reject();
        t_shutdown();
        t_midreset();
        summarize();
    end

    // Whole run needs about six hundred clocks
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        summarize();
    end

endmodule // testbench
`default_nettype wire
